// File: rtl/serial_port_ctrl.sv
// Serial port control registers behind an AHB-Lite slave.
// Assumes a shift engine on the same clock driving engine_evt and obeying engine_ctl.
`timescale 1ns/10ps
`default_nettype none

module serial_port_ctrl
    import serial_port_pkg::*;
(
    input wire logic hclk, // 40 MHz bus clock
    input wire logic hresetn, // Asynchronous reset, low
    input wire logic ce, // Clock enable, freezes all state
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic hready, // Bus ready
    input wire logic [31:0] hwdata, // Write data
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    input wire engine_evt_s engine_evt, // Shift engine events
    output engine_ctl_s engine_ctl, // Shift engine controls
    output logic err_irq, // Gated error request
    output logic rx_irq, // Gated receive request
    output logic tx_irq, // Gated transmit request
    output logic [1:0] serial_prio // Serial interrupt level
);

    ////////////////////////////////////////////////////////////////////////////
    // Parity of the data bits plus the odd selector
    function automatic logic calc_parity(input logic [7:0] d, input logic seven, input logic odd);
        logic p;
        p = (^d[6:0]) ^ (seven ? 1'b0 : d[7]) ^ odd;
        return p;
    endfunction : calc_parity

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0] prio_r; // Priority register, all bits kept
    logic [7:0] ien_r; // Enable register, all bits kept
    logic [2:0] ipend_r; // Serial pending flags
    logic [6:0] mode_r; // Mode register bits 6..0
    logic tx_en_r; // Transmit enable
    logic rx_en_r; // Receive enable
    logic tx_trg_r; // Transmit running
    logic rx_trg_r; // Receive running
    logic ovr_r; // Overrun flag
    logic par_r; // Parity error flag
    logic frm_r; // Framing error flag
    logic [7:0] tx_buf_r; // Transmit byte
    logic [7:0] rx_buf_r; // Receive buffer
    logic buf_full_r; // Buffer not yet released
    logic tx_start_r; // Start pulses
    logic rx_start_r;
    logic tx_par_r; // Appended parity bit
    clk_src_e clk_eff_r; // Effective clock source
    logic err_irq_r; // Gated requests
    logic rx_irq_r;
    logic tx_irq_r;
    logic [31:0] hrdata_r; // Bus answer
    logic hreadyout_r;
    logic hresp_r;
    logic wr_q_r; // Write data phase pending
    logic rd_q_r; // Read wait cycle pending
    logic [29:0] idx_q_r; // Captured index

    ////////////////////////////////////////////////////////////////////////////
    // Decoded conditions
    logic addr_ok; // Valid address phase
    logic wr_act; // Write data on bus this cycle
    logic [7:0] wd; // Written byte
    logic wr_prio, wr_ien, wr_iflg, wr_mode, wr_stat, wr_data;
    logic is_async; // Asynchronous mode
    logic seven; // 7-bit frame
    logic par_on; // Parity active
    logic tx_go; // Transmit trigger write accepted
    logic rx_go; // Receive trigger write accepted
    logic rxd; // Receive frame event
    logic rx_par_got; // Received parity bit
    logic par_bad; // Parity mismatch
    logic frm_bad; // Stop bit low
    logic ovr_bad; // Buffer overwritten
    logic err_evt; // Any receive error

    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_act = ce && wr_q_r;
    assign wd = hwdata[7:0];
    assign wr_prio = wr_act && (idx_q_r == IDX_PRIO);
    assign wr_ien = wr_act && (idx_q_r == IDX_IEN);
    assign wr_iflg = wr_act && (idx_q_r == IDX_IFLG);
    assign wr_mode = wr_act && (idx_q_r == IDX_MODE);
    assign wr_stat = wr_act && (idx_q_r == IDX_STAT);
    assign wr_data = wr_act && (idx_q_r == IDX_DATA);
    assign is_async = mode_r[B_XMODE+1]; // R1
    assign seven = (mode_r[B_XMODE+:2] == XM_ASYNC7);
    assign par_on = is_async && mode_r[B_PEN]; // R16
    assign tx_go = wr_stat && wd[B_TX_TRIGGER] && tx_en_r; // R18
    assign rx_go = wr_stat && wd[B_RX_TRIGGER] && rx_en_r; // R19
    assign rxd = ce && engine_evt.rx_done && rx_en_r;
    // In 7-bit frames the parity occupies the top data position
    assign rx_par_got = seven ? engine_evt.rx_frame[7] : engine_evt.rx_par_bit; // R16
    assign par_bad = rxd && par_on
        && (rx_par_got != calc_parity(engine_evt.rx_frame, seven, mode_r[B_PODD])); // R17
    assign frm_bad = rxd && is_async && !engine_evt.rx_stop_bit; // R5
    // Overlap of release and arrival still counts, as the old byte is lost
    assign ovr_bad = rxd && is_async && buf_full_r; // R6
    assign err_evt = par_bad || frm_bad || ovr_bad;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: writes commit in the data phase, reads take one wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q_r <= 1'b0;
            rd_q_r <= 1'b0;
            idx_q_r <= 30'h0;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else if (ce) begin
            wr_q_r <= addr_ok && hwrite;
            rd_q_r <= addr_ok && !hwrite;
            hreadyout_r <= !(addr_ok && !hwrite); // Wait lets a prior write land
            if (addr_ok) begin
                // Misaligned byte addresses never match a register
                idx_q_r <= (haddr[1:0] == 2'b00) ? haddr[31:2] : 30'h3fffffff;
            end
        end
    end

    // Read mux, sampled in the wait cycle; unmapped words read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0;
        end else if (ce && rd_q_r) begin
            if (idx_q_r == IDX_PRIO) begin
                hrdata_r <= {24'h0, prio_r}; // R9
            end else if (idx_q_r == IDX_IEN) begin
                hrdata_r <= {24'h0, ien_r};
            end else if (idx_q_r == IDX_IFLG) begin
                hrdata_r <= {29'h0, ipend_r};
            end else if (idx_q_r == IDX_MODE) begin
                hrdata_r <= {25'h0, mode_r}; // R21
            end else if (idx_q_r == IDX_STAT) begin
                hrdata_r <= {25'h0, frm_r, par_r, ovr_r, rx_trg_r, rx_en_r, tx_trg_r, tx_en_r}; // R21
            end else if (idx_q_r == IDX_DATA) begin
                hrdata_r <= {24'h0, rx_buf_r}; // R7
            end else begin
                hrdata_r <= 32'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= RST_REG[6:0];
            prio_r <= RST_REG;
            ien_r <= RST_REG;
        end else begin
            if (wr_mode) begin
                mode_r <= wd[6:0]; // R1 R2 R4 R16 R17
            end
            if (wr_prio) begin
                prio_r <= wd; // R9
            end
            if (wr_ien) begin
                ien_r <= wd; // R10 R11 R12
            end
        end
    end

    // Effective clock source; slave mode always follows the external clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_eff_r <= CS_DIV16;
        end else if (ce) begin
            if (mode_r[B_XMODE+:2] == XM_SYNC_SLAVE) begin
                clk_eff_r <= CS_EXT; // R3
            end else begin
                clk_eff_r <= clk_src_e'({1'b0, mode_r[B_CLKSRC+:2]}); // R2
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enables and transmit side
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_en_r <= 1'b0;
            rx_en_r <= 1'b0;
            tx_trg_r <= 1'b0;
            tx_start_r <= 1'b0;
            tx_par_r <= 1'b0;
        end else if (ce) begin
            if (wr_stat) begin
                tx_en_r <= wd[B_TX_ENABLE]; // R20
                rx_en_r <= wd[B_RX_ENABLE]; // R20
            end
            tx_start_r <= tx_go; // R18
            if (tx_go) begin
                tx_trg_r <= 1'b1; // R18
                tx_par_r <= calc_parity(tx_buf_r, seven, mode_r[B_PODD]); // R16
            end else if (engine_evt.tx_done || !tx_en_r) begin
                tx_trg_r <= 1'b0; // R18
            end
        end
    end

    // Transmit byte; loading it does not start anything
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_buf_r <= RST_DATA;
        end else if (wr_data) begin
            tx_buf_r <= wd; // R7 R8
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive side: trigger, buffer and occupancy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_trg_r <= 1'b0;
            rx_start_r <= 1'b0;
            buf_full_r <= 1'b0;
            rx_buf_r <= RST_DATA;
        end else if (ce) begin
            rx_start_r <= rx_go && !is_async; // R19
            if (rx_go) begin
                rx_trg_r <= 1'b1; // R19
            end else if (!rx_en_r || (rxd && !is_async)) begin
                rx_trg_r <= 1'b0; // R19
            end
            // New frame wins over a release in the same cycle
            if (rxd) begin
                buf_full_r <= 1'b1;
            end else if (rx_go || !rx_en_r) begin
                buf_full_r <= 1'b0; // R19
            end
            if (rxd) begin
                // The parity slot reads zero in 7-bit frames with parity
                rx_buf_r <= {engine_evt.rx_frame[7] && !(seven && par_on), engine_evt.rx_frame[6:0]}; // R8
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error flags: set wins over a write-one clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frm_r <= 1'b0;
            par_r <= 1'b0;
            ovr_r <= 1'b0;
        end else if (ce) begin
            frm_r <= frm_bad || (frm_r && !(wr_stat && wd[B_FRM])); // R5
            par_r <= par_bad || (par_r && !(wr_stat && wd[B_PAR])); // R6
            // Disabling the receiver also drops a stale overrun
            ovr_r <= ovr_bad || (ovr_r && !(wr_stat && wd[B_OVR]) && rx_en_r); // R6
        end
    end

    // Pending flags: set wins over a write-one clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ipend_r <= RST_REG[2:0];
        end else if (ce) begin
            ipend_r[B_ERR] <= err_evt || (ipend_r[B_ERR] && !(wr_iflg && wd[B_ERR])); // R13
            ipend_r[B_RXC] <= rxd || (ipend_r[B_RXC] && !(wr_iflg && wd[B_RXC])); // R14
            ipend_r[B_TXC] <= (engine_evt.tx_done && tx_trg_r)
                || (ipend_r[B_TXC] && !(wr_iflg && wd[B_TXC])); // R15
        end
    end

    // Gated requests toward the interrupt controller
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_irq_r <= 1'b0;
            rx_irq_r <= 1'b0;
            tx_irq_r <= 1'b0;
        end else if (ce) begin
            err_irq_r <= ipend_r[B_ERR] && ien_r[B_ERR]; // R10
            rx_irq_r <= ipend_r[B_RXC] && ien_r[B_RXC]; // R11
            tx_irq_r <= ipend_r[B_TXC] && ien_r[B_TXC]; // R12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all taken from flip-flops
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign err_irq = err_irq_r;
    assign rx_irq = rx_irq_r;
    assign tx_irq = tx_irq_r;
    assign serial_prio = prio_r[B_SPRIO+:2]; // R9
    assign engine_ctl.pin_en = mode_r[B_PIN_EN]; // R4
    assign engine_ctl.mode = xfer_mode_e'(mode_r[B_XMODE+:2]); // R1
    assign engine_ctl.clk_src = clk_eff_r;
    assign engine_ctl.parity_en = mode_r[B_PEN];
    assign engine_ctl.parity_odd = mode_r[B_PODD];
    assign engine_ctl.tx_en = tx_en_r;
    assign engine_ctl.rx_en = rx_en_r;
    assign engine_ctl.tx_start = tx_start_r;
    assign engine_ctl.rx_start = rx_start_r;
    assign engine_ctl.tx_data = tx_buf_r;
    assign engine_ctl.tx_par = tx_par_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_slave_clock: assert property (@(posedge hclk) disable iff (!hresetn) // R3
        ce && mode_r[B_XMODE+:2] == XM_SYNC_SLAVE |=> clk_eff_r == CS_EXT)
        else $error("slave mode without external clock");

    chk_frame_flag: assert property (@(posedge hclk) disable iff (!hresetn) // R5
        frm_bad |=> frm_r ##1 (frm_r || $past(wr_stat && wd[B_FRM])))
        else $error("framing flag not held");

    chk_overrun_set: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        ce && engine_evt.rx_done && rx_en_r && is_async && buf_full_r |=> ovr_r && ipend_r[B_ERR])
        else $error("overrun not flagged");

    chk_parity_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R16
        rxd && !is_async && !wr_stat |=> $stable(frm_r) && $stable(par_r) && $stable(ovr_r))
        else $error("error flag moved outside async mode");

    chk_tx_trigger: assert property (@(posedge hclk) disable iff (!hresetn) // R18
        tx_go |=> tx_trg_r && engine_ctl.tx_start ##1 !engine_ctl.tx_start)
        else $error("transmit start not seen");

    chk_rx_sync_stop: assert property (@(posedge hclk) disable iff (!hresetn) // R19
        rxd && !is_async && !rx_go |=> !rx_trg_r && ipend_r[B_RXC])
        else $error("sync receive did not stop");

    chk_pend_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R15
        wr_iflg && wd[B_TXC] && !engine_evt.tx_done |=> !ipend_r[B_TXC])
        else $error("transmit pending not cleared");

    chk_err_gate: assert property (@(posedge hclk) disable iff (!hresetn) // R10
        ce && !ien_r[B_ERR] ##1 ce |-> !err_irq_r)
        else $error("error request while disabled");

    chk_read_wait: assert property (@(posedge hclk) disable iff (!hresetn) // R21
        ce && addr_ok && !hwrite && haddr[31:2] == IDX_MODE && haddr[1:0] == 2'b00
        |=> !hreadyout_r ##1 (!ce || (hreadyout_r && !hrdata_r[7])))
        else $error("mode read wrong");

endmodule : serial_port_ctrl

`default_nettype wire

// File: rtl/serial_port_pkg.sv
// Constants, types and carriers of the serial port control registers.
// Assumes a 32-bit AHB-Lite bus; each 8-bit register sits in the low byte of one word.
// Functional notes
// (R1) Two-bit field selects one of four transfer modes
// (R2) Two-bit field selects the bit clock source
// (R3) Synchronous slave uses external clock, ignores selection
// (R4) Port enable routes pins to serial port
// (R5) Framing flag sets on error, write one clears
// (R6) Overrun and parity flags sticky, write one clears; overrun also drops while the receiver is disabled
// (R7) One data byte: write transmits, read receives
// (R8) Bit 0 first serial bit; one is high
// (R9) Two-bit serial interrupt priority, read/write, resets zero
// (R10) Error interrupt gated by enable bit 2
// (R11) Receive interrupt gated by enable bit 1
// (R12) Transmit interrupt gated by enable bit 0
// (R13) Error pending flag sets on cause, write-one clears
// (R14) Receive pending flag sets on cause, write-one clears
// (R15) Transmit pending flag sets on cause, write-one clears
// (R16) Parity enable checks and appends parity, asynchronous only
// (R17) Parity mode one odd, zero even
// (R18) Data first, then trigger; trigger reads busy
// (R19) Receive trigger starts or frees buffer; reads busy
// (R20) Status bit 0 transmit enable, bit 2 receive
// (R21) Bit 7 of mode and status read zero
package serial_port_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index
    localparam logic [29:0] IDX_PRIO = 30'h0000ff20; // Interrupt priority
    localparam logic [29:0] IDX_IEN = 30'h0000ff23; // Interrupt enables
    localparam logic [29:0] IDX_IFLG = 30'h0000ff25; // Interrupt pending flags
    localparam logic [29:0] IDX_MODE = 30'h0000ff48; // Mode and clock config
    localparam logic [29:0] IDX_STAT = 30'h0000ff49; // Control and status
    localparam logic [29:0] IDX_DATA = 30'h0000ff4a; // Shared data byte

    // Field positions
    localparam int B_PIN_EN = 0; // Mode: serial pin enable
    localparam int B_XMODE = 1; // Mode: transfer mode, two bits
    localparam int B_CLKSRC = 3; // Mode: clock source, two bits
    localparam int B_PODD = 5; // Mode: odd parity
    localparam int B_PEN = 6; // Mode: parity enable
    localparam int B_TX_ENABLE = 0; // Status: transmit enable
    localparam int B_TX_TRIGGER = 1; // Status: transmit trigger
    localparam int B_RX_ENABLE = 2; // Status: receive enable
    localparam int B_RX_TRIGGER = 3; // Status: receive trigger
    localparam int B_OVR = 4; // Status: overrun flag
    localparam int B_PAR = 5; // Status: parity flag
    localparam int B_FRM = 6; // Status: framing flag
    localparam int B_SPRIO = 4; // Priority: serial level, two bits
    localparam int B_ERR = 2; // Enable and pending: error
    localparam int B_RXC = 1; // Enable and pending: receive complete
    localparam int B_TXC = 0; // Enable and pending: transmit complete

    // Values after reset
    localparam logic [7:0] RST_REG = 8'h00; // All control registers
    localparam logic [7:0] RST_DATA = 8'h00; // Data is undefined; zero chosen

    // Transfer modes
    typedef enum logic [1:0] {
        XM_SYNC_MASTER = 2'b00,
        XM_SYNC_SLAVE = 2'b01,
        XM_ASYNC7 = 2'b10,
        XM_ASYNC8 = 2'b11
    } xfer_mode_e;

    // Effective bit clock source
    typedef enum logic [2:0] {
        CS_DIV16 = 3'b000,
        CS_DIV8 = 3'b001,
        CS_DIV4 = 3'b010,
        CS_TIMER = 3'b011,
        CS_EXT = 3'b100
    } clk_src_e;

    // Events from the shift engine
    typedef struct packed {
        logic tx_done; // Last bit sent
        logic rx_done; // Frame moved to buffer
        logic [7:0] rx_frame; // Received bits, first bit at 0
        logic rx_par_bit; // Parity bit of 8-bit frames
        logic rx_stop_bit; // Sampled stop bit
    } engine_evt_s;

    // Controls to the shift engine and pins
    typedef struct packed {
        logic pin_en; // Pins belong to the serial port
        xfer_mode_e mode; // Transfer mode
        clk_src_e clk_src; // Effective clock source
        logic parity_en; // Parity enable bit, passed on in every transfer mode
        logic parity_odd; // Odd parity
        logic tx_en; // Transmit enabled
        logic rx_en; // Receive enabled
        logic tx_start; // One-cycle start pulse
        logic rx_start; // One-cycle synchronous start pulse
        logic [7:0] tx_data; // Byte to send
        logic tx_par; // Parity bit to append
    } engine_ctl_s;

endpackage : serial_port_pkg

// File: verif/serial_engine_model.sv
// Behavioural shift engine that faces the serial control registers.
// Assumes it shares the register clock; the bench hands it received frames by task.
`timescale 1ns/10ps
`default_nettype none

module serial_engine_model
    import serial_port_pkg::*;
(
    input wire logic hclk, // Shared clock
    input wire engine_ctl_s ctl, // Controls from the block
    output var engine_evt_s evt // Events to the block
);
    int tx_dly = 8; // Send time in cycles, bench may stretch it
    int cnt = 0; // Cycles left in a send
    int rx_starts = 0; // Synchronous receive starts seen
    logic [7:0] sent_data = 8'h00; // Byte taken at start
    logic sent_par = 1'b0; // Parity bit taken at start

    ////////////////////////////////////////////////////////////////////////////
    // Send timing: done pulse a set time after each start pulse
    initial evt = '0;
    always @(posedge hclk) begin
        evt.tx_done <= 1'b0;
        if (ctl.tx_start) begin
            sent_data <= ctl.tx_data;
            sent_par <= ctl.tx_par;
            cnt <= tx_dly;
        end else if (cnt == 1) begin // Last bit out
            evt.tx_done <= 1'b1;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
        if (ctl.rx_start) begin
            rx_starts <= rx_starts + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One frame into the buffer; fields scramble once the pulse is over,
    // so a block that samples late sees garbage rather than a lucky match
    task automatic send_frame(input logic [7:0] d, input logic p, input logic s);
        evt.rx_frame <= d;
        evt.rx_par_bit <= p;
        evt.rx_stop_bit <= s;
        evt.rx_done <= 1'b1;
        @(posedge hclk);
        evt.rx_done <= 1'b0;
        evt.rx_frame <= ~d;
        evt.rx_par_bit <= ~p;
        evt.rx_stop_bit <= ~s;
    endtask : send_frame
endmodule : serial_engine_model

`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the serial control registers over AHB-Lite.
// Assumes a single slave, so hready is the slave's own hreadyout.
`timescale 1ns/10ps
`default_nettype none

module tb
    import serial_port_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite; // Bus control
    logic ce = 1'b1; // Clock enable held on
    logic [31:0] haddr, hwdata, hrdata, rd; // Bus data
    logic [1:0] htrans; // Transfer type
    logic [2:0] hsize; // Always a word
    logic hreadyout, hresp, err_irq, rx_irq, tx_irq; // Slave outputs
    logic [1:0] serial_prio; // Priority level
    engine_evt_s evt; // Partner events
    engine_ctl_s ctl; // Partner controls
    logic [7:0] v, d; // Random bytes
    int error_cnt = 0, num_checks = 0, seed = 32'hef826fe4, k; // Counters

    serial_port_ctrl i_serial_port_ctrl (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .engine_evt(evt), .engine_ctl(ctl), .err_irq(err_irq),
        .rx_irq(rx_irq), .tx_irq(tx_irq), .serial_prio(serial_prio));
    serial_engine_model i_serial_engine_model (.hclk(hclk), .ctl(ctl), .evt(evt));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog; the whole run needs a few hundred cycles
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparison, single bus transfer and register helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Expected clock source and appended parity
    function automatic logic [31:0] exp_clk(input logic [7:0] m);
        return (m[2:1] == 2'b01) ? 32'(CS_EXT) : 32'(m[4:3]);
    endfunction : exp_clk
    function automatic logic exp_par(input logic [7:0] b, input logic odd);
        return ^b ^ odd;
    endfunction : exp_par
    task bus(input logic w, input logic [31:0] a, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk); // Address phase held until ready
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk); // Data phase held until ready
        rd = hrdata;
    endtask : bus
    task wr(input logic [29:0] idx, input logic [7:0] wd);
        bus(1'b1, {idx, 2'b00}, wd);
    endtask : wr
    task rdchk(input string nm, input logic [29:0] idx, input logic [7:0] exp);
        bus(1'b0, {idx, 2'b00}, 8'h00);
        chk(nm, rd, {24'h0, exp});
    endtask : rdchk
    task results;
        $display("Checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'b010;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk("mode rst", IDX_MODE, 8'h00);
        rdchk("stat rst", IDX_STAT, 8'h00);
        rdchk("prio rst", IDX_PRIO, 8'h00);
        rdchk("ien rst", IDX_IEN, 8'h00);
        rdchk("iflg rst", IDX_IFLG, 8'h00);
        // Every mode against every clock source, other bits random
        for (int i = 0; i < 16; i++) begin
            v = 8'($random(seed));
            v[4:1] = i[3:0];
            wr(IDX_MODE, v);
            rdchk("mode", IDX_MODE, v & 8'h7f);
            chk("pin_en", 32'(ctl.pin_en), 32'(v[0]));
            chk("xmode", 32'(ctl.mode), 32'(v[2:1]));
            chk("clk_src", 32'(ctl.clk_src), exp_clk(v));
            chk("parity", 32'({ctl.parity_en, ctl.parity_odd}), 32'(v[6:5]));
        end
        v = 8'($random(seed));
        wr(IDX_PRIO, v);
        rdchk("prio", IDX_PRIO, v);
        chk("serial_prio", 32'(serial_prio), 32'(v[5:4]));
        // Unmapped index and a misaligned address both read zero
        wr(IDX_DATA + 30'h1, 8'hff);
        rdchk("unmapped", IDX_DATA + 30'h1, 8'h00);
        bus(1'b0, {IDX_MODE, 2'b01}, 8'h00);
        chk("misaligned", rd, 32'h0);
        chk("resp", 32'(hresp), 32'h0);
        wr(IDX_STAT, 8'h02);
        rdchk("tx refused", IDX_STAT, 8'h00);
        // Send with even then odd parity; prompt then slow far side, irq on then off
        for (int j = 0; j < 2; j++) begin
            i_serial_engine_model.tx_dly = j ? 40 : 8;
            d = 8'($random(seed));
            wr(IDX_IEN, j ? 8'h00 : 8'h07);
            wr(IDX_MODE, {2'b01, j[0], 2'b00, 2'b11, 1'b1});
            wr(IDX_DATA, d);
            wr(IDX_STAT, 8'h01);
            wr(IDX_STAT, 8'h03);
            rdchk("tx busy", IDX_STAT, 8'h03);
            k = 0;
            while (rd[1] && k < 60) begin
                bus(1'b0, {IDX_STAT, 2'b00}, 8'h00);
                k++;
            end
            chk("tx data", 32'(i_serial_engine_model.sent_data), 32'(d));
            chk("tx par", 32'(i_serial_engine_model.sent_par), 32'(exp_par(d, j[0])));
            rdchk("tx idle", IDX_STAT, 8'h01);
            rdchk("tx pend", IDX_IFLG, 8'h01);
            chk("tx irq", 32'(tx_irq), 32'(!j));
            wr(IDX_IFLG, 8'h00);
            rdchk("tx w0", IDX_IFLG, 8'h01);
            wr(IDX_IFLG, 8'h01);
            rdchk("tx w1c", IDX_IFLG, 8'h00);
        end
        // Async receive: a clean frame, then a bad one without freeing the buffer
        wr(IDX_IEN, 8'h06);
        wr(IDX_MODE, 8'h47);
        wr(IDX_STAT, 8'h04);
        wr(IDX_STAT, 8'h0c);
        d = 8'($random(seed));
        i_serial_engine_model.send_frame(d, ^d, 1'b1);
        rdchk("rx data", IDX_DATA, d);
        rdchk("rx pend", IDX_IFLG, 8'h02);
        rdchk("rx ok", IDX_STAT, 8'h0c);
        d = 8'($random(seed));
        i_serial_engine_model.send_frame(d, ~^d, 1'b0);
        rdchk("rx err", IDX_STAT, 8'h7c);
        rdchk("err pend", IDX_IFLG, 8'h06);
        chk("irqs", {err_irq, rx_irq, tx_irq}, 32'h6);
        wr(IDX_STAT, 8'h0c);
        rdchk("err w0", IDX_STAT, 8'h7c);
        wr(IDX_STAT, 8'h7c);
        rdchk("err w1c", IDX_STAT, 8'h0c);
        wr(IDX_IFLG, 8'h06);
        rdchk("pend w1c", IDX_IFLG, 8'h00);
        // Sync receive: trigger refused while disabled, then a start and its frame
        wr(IDX_MODE, 8'h01);
        wr(IDX_STAT, 8'h00); // Receiver off before the refused trigger
        wr(IDX_STAT, 8'h08);
        rdchk("rx refused", IDX_STAT, 8'h00);
        wr(IDX_STAT, 8'h04);
        wr(IDX_STAT, 8'h0c);
        rdchk("rx run", IDX_STAT, 8'h0c);
        chk("rx start", i_serial_engine_model.rx_starts, 32'h1);
        i_serial_engine_model.send_frame(8'ha5, 1'b0, 1'b1);
        rdchk("rx stop", IDX_STAT, 8'h04);
        results();
    end
endmodule : tb

`default_nettype wire
